// file: src/dbk_addr_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// one address comparator with optional low-byte and r/w qualification
module dbk_addr_cmp
    import dbk_pkg::*;
(
    // bus
    input wire logic [15:0] bus_addr,
    input wire logic bus_read,
    // setup
    input wire logic [15:0] cmp_addr,
    input wire logic low_byte_address_compare,
    input wire logic rw_compare_enable,
    input wire logic rw_compare_value,
    // result
    output logic hit
);
    // range compare drops the low byte when low-byte compare is off
    always_comb begin
        hit = (bus_addr[15:8] == cmp_addr[15:8]);
        if (low_byte_address_compare) begin
            hit = hit && (bus_addr[7:0] == cmp_addr[7:0]);
        end
        if (rw_compare_enable) begin
            hit = hit && (bus_read == rw_compare_value);
        end
    end
endmodule : dbk_addr_cmp
`default_nettype wire

// file: src/dbk_pkg.sv
package dbk_pkg;
    // register addresses on the cpu core bus
    localparam logic [15:0] DBK_SHIFT_HI_ADDR = 16'hff02;
    localparam logic [15:0] DBK_SHIFT_LO_ADDR = 16'hff03;
    localparam logic [15:0] DBK_ADDR_HI_ADDR = 16'hff04;
    localparam logic [15:0] DBK_ADDR_LO_ADDR = 16'hff05;
    localparam logic [15:0] DBK_CCR_SAVE_ADDR = 16'hff06;
    // reset values for the storage registers
    localparam logic [15:0] DBK_SHIFT_RST = 16'h0000;
    localparam logic [15:0] DBK_ADDR_RST = 16'h0000;
    localparam logic [7:0] DBK_CCR_RST = 8'h00;
    // read-next and write-next pre-increment of index x
    localparam logic [15:0] DBK_NEXT_STEP = 16'h0002;
    // register-select field codes
    localparam logic [2:0] DBK_SEL_NONE0 = 3'h0;
    localparam logic [2:0] DBK_SEL_NONE1 = 3'h1;
    localparam logic [2:0] DBK_SEL_NEXT = 3'h2;
    localparam logic [2:0] DBK_SEL_PC = 3'h3;
    localparam logic [2:0] DBK_SEL_D = 3'h4;
    localparam logic [2:0] DBK_SEL_X = 3'h5;
    localparam logic [2:0] DBK_SEL_Y = 3'h6;
    localparam logic [2:0] DBK_SEL_SP = 3'h7;
    // breakpoint mode selector codes
    localparam logic [1:0] DBK_MODE_OFF = 2'h0;
    localparam logic [1:0] DBK_MODE_SWI_DUAL = 2'h1;
    localparam logic [1:0] DBK_MODE_BDM_FULL = 2'h2;
    localparam logic [1:0] DBK_MODE_BDM_DUAL = 2'h3;
    // binary-encoded register targets
    typedef enum logic [2:0] {
        DBK_TGT_NONE,
        DBK_TGT_NEXT,
        DBK_TGT_PC,
        DBK_TGT_D,
        DBK_TGT_X,
        DBK_TGT_Y,
        DBK_TGT_SP
    } dbk_target_t;
endpackage : dbk_pkg

// file: src/dbk_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - decode register-select field to register target
// - next commands add two to x first
// - sixteen-bit shift register readable and writable
// - address hold register, debug-loaded, read-only
// - save condition code on debug entry
// - compare bus to setup, break on match
// - exactly three breakpoint modes
// - no breakpoints while debug mode active
// - only swi dual mode raises swi
// - swi dual ignores r/w compare settings
// - data-compare enable arms second breakpoint
// - size select ignored in dual modes
// - debug entry only when debug enabled
// - no hardware block when enable clear
// - debug dual honours all per-breakpoint settings except r/w compare, which program-only break drops
// - full mode data compare with byte masks
// - range compare by dropping low byte
// - tagged fetch breaks only on execution
// - tagging inhibited during single-step command
// - two-bit selector chooses breakpoint mode
// - program-only break or swi dual mode uses tagging, else boundary
module dbk_top
    import dbk_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // cpu core bus register access
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // debug hardware side
    input wire logic shift_load,
    input wire logic [15:0] shift_load_data,
    input wire logic addr_load,
    input wire logic [15:0] addr_load_data,
    input wire logic [2:0] register_select_field,
    input wire logic [15:0] index_x,
    output logic [2:0] cmd_target,
    output logic [15:0] next_addr,
    // debug state
    input wire logic background_debug_mode,
    input wire logic debug_enabled,
    input wire logic debug_entry,
    input wire logic [7:0] condition_code_value,
    input wire logic single_step_command,
    // breakpoint setup
    input wire logic [1:0] breakpoint_mode_select,
    input wire logic program_only_break,
    input wire logic [1:0] low_byte_address_compare,
    input wire logic data_compare_enable,
    input wire logic mask_high,
    input wire logic mask_low,
    input wire logic [1:0] rw_compare_enable,
    input wire logic [1:0] rw_compare_value,
    input wire logic size_select,
    input wire logic [15:0] bkp_addr,
    input wire logic [15:0] bkp_data,
    // cpu bus monitor
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_data,
    input wire logic bus_read,
    input wire logic bus_fetch,
    input wire logic tag_execute,
    input wire logic inst_boundary,
    // breakpoint results
    output logic tag_fetch,
    output logic debug_break_req,
    output logic software_interrupt
);
    logic [15:0] shift_r;
    logic [15:0] addr_hold_r;
    logic [7:0] ccr_save_r;
    logic pending_r;
    logic tag_armed_r;
    logic hit0, hit1, data_hit, match, tag_mode, swi_mode, bdm_mode;
    logic [15:0] unused_wide;

    // register-select decode, handed to the firmware command path
    always_comb begin
        case (register_select_field)
            DBK_SEL_NONE0: cmd_target = DBK_TGT_NONE;
            DBK_SEL_NONE1: cmd_target = DBK_TGT_NONE;
            DBK_SEL_NEXT: cmd_target = DBK_TGT_NEXT;
            DBK_SEL_PC: cmd_target = DBK_TGT_PC;
            DBK_SEL_D: cmd_target = DBK_TGT_D;
            DBK_SEL_X: cmd_target = DBK_TGT_X;
            DBK_SEL_Y: cmd_target = DBK_TGT_Y;
            DBK_SEL_SP: cmd_target = DBK_TGT_SP;
            default: cmd_target = DBK_TGT_NONE;
        endcase
    end

    // pre-incremented pointer; wraps at top of map like the cpu
    assign next_addr = 16'(index_x + DBK_NEXT_STEP);

    // shift register: serial load wins over a cpu write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_r <= DBK_SHIFT_RST;
        end else if (shift_load) begin
            shift_r <= shift_load_data;
        end else if (reg_wr && reg_addr == DBK_SHIFT_HI_ADDR) begin
            shift_r[15:8] <= reg_wdata;
        end else if (reg_wr && reg_addr == DBK_SHIFT_LO_ADDR) begin
            shift_r[7:0] <= reg_wdata;
        end
    end

    // address hold: only the debug state machine loads it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_hold_r <= DBK_ADDR_RST;
        end else if (addr_load) begin
            addr_hold_r <= addr_load_data;
        end
    end

    // condition code save: entry capture beats firmware write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ccr_save_r <= DBK_CCR_RST;
        end else if (debug_entry) begin
            ccr_save_r <= condition_code_value;
        end else if (reg_wr && reg_addr == DBK_CCR_SAVE_ADDR) begin
            ccr_save_r <= reg_wdata;
        end
    end

    // read data from flops, zero for unmapped addresses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                DBK_SHIFT_HI_ADDR: reg_rdata <= shift_r[15:8];
                DBK_SHIFT_LO_ADDR: reg_rdata <= shift_r[7:0];
                DBK_ADDR_HI_ADDR: reg_rdata <= addr_hold_r[15:8];
                DBK_ADDR_LO_ADDR: reg_rdata <= addr_hold_r[7:0];
                DBK_CCR_SAVE_ADDR: reg_rdata <= ccr_save_r;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // mode decode
    assign swi_mode = (breakpoint_mode_select == DBK_MODE_SWI_DUAL);
    assign bdm_mode = (breakpoint_mode_select == DBK_MODE_BDM_FULL) ||
                      (breakpoint_mode_select == DBK_MODE_BDM_DUAL);
    // swi mode always tags program fetches
    assign tag_mode = swi_mode || program_only_break;

    // breakpoint 0 address compare; r/w ignored in swi mode
    dbk_addr_cmp u_cmp0 (
        .bus_addr(bus_addr),
        .bus_read(bus_read),
        .cmp_addr(bkp_addr),
        .low_byte_address_compare(low_byte_address_compare[0]),
        .rw_compare_enable(rw_compare_enable[0] && !swi_mode && !tag_mode),
        .rw_compare_value(rw_compare_value[0]),
        .hit(hit0)
    );

    // breakpoint 1 uses the data setup as a second address in dual modes
    dbk_addr_cmp u_cmp1 (
        .bus_addr(bus_addr),
        .bus_read(bus_read),
        .cmp_addr(bkp_data),
        .low_byte_address_compare(low_byte_address_compare[1]),
        .rw_compare_enable(rw_compare_enable[1] && !swi_mode && !tag_mode),
        .rw_compare_value(rw_compare_value[1]),
        .hit(hit1)
    );

    // full mode data compare with per-byte masks; size select never used
    assign data_hit = (!data_compare_enable) ||
                      ((mask_high || bus_data[15:8] == bkp_data[15:8]) &&
                       (mask_low || bus_data[7:0] == bkp_data[7:0]));
    assign unused_wide = {15'h0000, size_select};

    // match per mode; second breakpoint armed by data-compare enable
    always_comb begin
        case (breakpoint_mode_select)
            DBK_MODE_SWI_DUAL: match = hit0 || (data_compare_enable && hit1);
            DBK_MODE_BDM_DUAL: match = hit0 || (data_compare_enable && hit1);
            DBK_MODE_BDM_FULL: match = hit0 && (tag_mode || data_hit);
            default: match = 1'b0;
        endcase
    end

    // fetch tag marks the opcode; never while debug active or tracing
    assign tag_fetch = match && tag_mode && bus_fetch &&
                       !background_debug_mode && !single_step_command;

    // tagged opcode armed until it executes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tag_armed_r <= 1'b0;
        end else if (background_debug_mode) begin
            tag_armed_r <= 1'b0;
        end else if (tag_fetch) begin
            tag_armed_r <= 1'b1;
        end else if (tag_execute) begin
            tag_armed_r <= 1'b0;
        end
    end

    // untagged match waits for the next instruction boundary
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pending_r <= 1'b0;
        end else if (background_debug_mode || breakpoint_mode_select == DBK_MODE_OFF) begin
            pending_r <= 1'b0;
        end else if (match && !tag_mode && !bus_fetch) begin
            pending_r <= 1'b1;
        end else if (match && !tag_mode) begin
            pending_r <= 1'b1;
        end else if (inst_boundary) begin
            pending_r <= 1'b0;
        end
    end

    // enable gates entry but is not enforced beyond that; firmware returns
    // and an unserviced match simply re-asserts
    always_comb begin
        debug_break_req = 1'b0;
        software_interrupt = 1'b0;
        if (!background_debug_mode) begin
            if (swi_mode) begin
                software_interrupt = tag_armed_r && tag_execute;
            end else if (bdm_mode && debug_enabled) begin
                debug_break_req = (tag_armed_r && tag_execute) ||
                                  (pending_r && inst_boundary);
            end
        end
    end
endmodule : dbk_top
`default_nettype wire

// file: verification/dbk_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu core bus, one read cycle per request
module dbk_cpu_model (
    // clock and request
    input wire logic sys_clk,
    input wire logic cyc_req,
    input wire logic [15:0] cyc_addr,
    // cpu bus
    output logic [15:0] bus_addr,
    output logic [15:0] bus_data,
    output logic bus_read,
    output logic bus_fetch
);
    logic [15:0] last_r = 16'h0000;
    // idle bus shows the inverse so a stale address never matches
    always @(posedge sys_clk) begin
        if (cyc_req) last_r <= cyc_addr;
    end
    // fixed data word, inverted when idle
    assign bus_addr = cyc_req ? cyc_addr : ~last_r;
    assign bus_data = cyc_req ? 16'h3320 : 16'hccdf;
    assign bus_read = cyc_req;
    assign bus_fetch = cyc_req; // reads stand in for opcode fetches
endmodule : dbk_cpu_model
`default_nettype wire

// file: verification/dbk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dbk_sva
    import dbk_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched ports
    input wire logic [2:0] register_select_field,
    input wire logic [2:0] cmd_target,
    input wire logic [15:0] index_x,
    input wire logic [15:0] next_addr,
    input wire logic background_debug_mode,
    input wire logic debug_enabled,
    input wire logic single_step_command,
    input wire logic [1:0] breakpoint_mode_select,
    input wire logic tag_fetch,
    input wire logic debug_break_req,
    input wire logic software_interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // decode and pointer step
    chk_sel_decode: assert property (register_select_field > 3'h1 |->
        cmd_target == register_select_field - 3'h1) else $error("bad decode");
    chk_next_step: assert property (next_addr == 16'(index_x + DBK_NEXT_STEP))
        else $error("bad next address");
    // break outputs
    chk_quiet_debug: assert property (background_debug_mode |->
        !debug_break_req && !software_interrupt) else $error("break in debug");
    chk_swi_mode: assert property (software_interrupt |->
        breakpoint_mode_select == DBK_MODE_SWI_DUAL) else $error("swi outside swi mode");
    chk_bdm_mode: assert property (debug_break_req |-> breakpoint_mode_select[1])
        else $error("debug break in wrong mode");
    chk_bdm_enable: assert property (debug_break_req |-> debug_enabled)
        else $error("debug break not enabled");
    // two cycles off leaves nothing pending behind
    chk_off_quiet: assert property ((breakpoint_mode_select == DBK_MODE_OFF) [*2] |->
        !debug_break_req && !software_interrupt) else $error("break while off");
    chk_step_notag: assert property (single_step_command |-> !tag_fetch)
        else $error("tag during step");
endmodule : dbk_sva
bind dbk_top dbk_sva u_sva (.sys_clk, .rst, .register_select_field, .cmd_target, .index_x,
    .next_addr, .background_debug_mode, .debug_enabled, .single_step_command,
    .breakpoint_mode_select, .tag_fetch, .debug_break_req, .software_interrupt);
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dbk_pkg::*;
    // bench-driven inputs
    logic sys_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, shift_load = 1'h0;
    logic addr_load = 1'h0, debug_entry = 1'h0, background_debug_mode = 1'h0;
    logic debug_enabled = 1'h0, single_step_command = 1'h0, program_only_break = 1'h0;
    logic data_compare_enable = 1'h1, mask_high = 1'h0, mask_low = 1'h0, size_select = 1'h1;
    logic tag_execute = 1'h0, inst_boundary = 1'h0, cyc_req = 1'h0;
    logic [1:0] breakpoint_mode_select = 2'h0, low_byte_address_compare = 2'h3;
    logic [1:0] rw_compare_enable = 2'h1, rw_compare_value = 2'h0;
    logic [2:0] register_select_field = 3'h0, cmd_target;
    logic [7:0] reg_wdata = 8'h00, condition_code_value = 8'h00, reg_rdata;
    logic [15:0] reg_addr = 16'h0000, shift_load_data = 16'h0000, addr_load_data = 16'h0000;
    logic [15:0] index_x = 16'h0000, bkp_addr = 16'h4a10, bkp_data = 16'h6c20;
    logic [15:0] cyc_addr = 16'h0000, bus_addr, bus_data, next_addr;
    logic bus_read, bus_fetch, tag_fetch, debug_break_req, software_interrupt;
    int fails = 0, n_checks = 0, cyc = 0;
    // 25 mhz
    always #20 sys_clk = ~sys_clk;
    dbk_top dut (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .shift_load, .shift_load_data, .addr_load, .addr_load_data, .register_select_field,
        .index_x, .cmd_target, .next_addr, .background_debug_mode, .debug_enabled,
        .debug_entry, .condition_code_value, .single_step_command, .breakpoint_mode_select,
        .program_only_break, .low_byte_address_compare, .data_compare_enable, .mask_high,
        .mask_low, .rw_compare_enable, .rw_compare_value, .size_select, .bkp_addr, .bkp_data,
        .bus_addr, .bus_data, .bus_read, .bus_fetch, .tag_execute, .inst_boundary,
        .tag_fetch, .debug_break_req, .software_interrupt);
    dbk_cpu_model u_cpu (.sys_clk, .cyc_req, .cyc_addr, .bus_addr, .bus_data, .bus_read,
        .bus_fetch);
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // one register cycle; a read is compared once the flop has landed
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input string nm);
        reg_addr <= a;
        reg_wdata <= d;
        {reg_wr, reg_rd} <= {w, !w};
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= 2'h0;
        @(negedge sys_clk);
        if (!w) chk(nm, 16'(d), 16'(reg_rdata));
        @(posedge sys_clk);
    endtask : acc
    // cfg is {mode, debug active, step, low byte compare, mask high}; e is {tag, debug, swi}
    task automatic hit(input logic [6:0] cfg, input logic [15:0] a, input logic [2:0] e,
            input string nm);
        {breakpoint_mode_select, background_debug_mode, single_step_command,
            low_byte_address_compare, mask_high} <= cfg;
        @(posedge sys_clk);
        {cyc_addr, cyc_req} <= {a, 1'h1};
        // the fetch tag only stands while the fetch cycle is on the bus
        @(negedge sys_clk);
        chk({nm, "_tag"}, 16'(e[2]), 16'(tag_fetch));
        @(posedge sys_clk);
        {cyc_req, inst_boundary, tag_execute} <= 3'h3;
        @(negedge sys_clk);
        chk(nm, 16'(e[1:0]), 16'({debug_break_req, software_interrupt}));
        @(posedge sys_clk);
        {inst_boundary, tag_execute} <= 2'h0;
        @(posedge sys_clk);
    endtask : hit
    task automatic conclude();
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // hang guard, far past the hundred or so cycles needed
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        acc(1'h0, DBK_CCR_SAVE_ADDR, DBK_CCR_RST, "ccr");
        acc(1'h0, 16'h0100, 8'h00, "unmapped");
        acc(1'h1, DBK_SHIFT_HI_ADDR, 8'ha5, "");
        acc(1'h1, DBK_CCR_SAVE_ADDR, 8'h96, "");
        acc(1'h0, DBK_SHIFT_HI_ADDR, 8'ha5, "shift_hi");
        acc(1'h0, DBK_CCR_SAVE_ADDR, 8'h96, "ccr");
        {addr_load_data, shift_load_data, condition_code_value} <= {16'h1234, 16'hbeef, 8'hc5};
        {addr_load, shift_load, debug_entry} <= 3'h7;
        @(posedge sys_clk);
        {addr_load, shift_load, debug_entry} <= 3'h0;
        acc(1'h1, DBK_ADDR_HI_ADDR, 8'hff, "");
        acc(1'h0, DBK_ADDR_HI_ADDR, 8'h12, "addr_hi");
        acc(1'h0, DBK_ADDR_LO_ADDR, 8'h34, "addr_lo");
        acc(1'h0, DBK_SHIFT_LO_ADDR, 8'hef, "shift_lo");
        acc(1'h0, DBK_CCR_SAVE_ADDR, 8'hc5, "ccr");
        for (int i = 0; i < 8; i++) begin
            register_select_field <= 3'(i);
            @(negedge sys_clk);
            chk("cmd_target", (i < 2) ? 16'h0000 : 16'(i - 1), 16'(cmd_target));
            @(posedge sys_clk);
        end
        index_x <= 16'hffff;
        @(negedge sys_clk);
        chk("next_addr", 16'h0001, next_addr);
        @(posedge sys_clk);
        debug_enabled <= 1'h1;
        hit(7'h26, 16'h4a10, 3'h5, "swi");
        hit(7'h2e, 16'h4a10, 3'h0, "step");
        hit(7'h66, 16'h4a10, 3'h0, "dual_rw");
        rw_compare_value <= 2'h1;
        hit(7'h66, 16'h4a10, 3'h2, "dual_bkp0");
        hit(7'h66, 16'h6c20, 3'h2, "dual_bkp1");
        hit(7'h74, 16'h4aff, 3'h0, "in_debug");
        hit(7'h64, 16'h4aff, 3'h2, "range");
        hit(7'h06, 16'h4a10, 3'h0, "off");
        {rw_compare_enable, size_select} <= 3'h0;
        hit(7'h47, 16'h4a10, 3'h2, "full");
        hit(7'h46, 16'h4a10, 3'h0, "full_mask");
        // program-only break goes through the tag and breaks on execution
        program_only_break <= 1'h1;
        hit(7'h66, 16'h4a10, 3'h6, "tagged");
        {debug_enabled, program_only_break} <= 2'h0;
        hit(7'h66, 16'h4a10, 3'h0, "disabled");
        {debug_enabled, data_compare_enable} <= 2'h2;
        hit(7'h66, 16'h6c20, 3'h0, "bkp1_off");
        conclude();
    end
endmodule : testbench
`default_nettype wire
